// ### lfd_pkg.sv
package lfd_pkg;
   localparam logic [2:0]  CODE_PASS       = 3'h3;
   localparam logic [2:0]  CODE_FAIL       = 3'h6;
   localparam logic [2:0]  CODE_RESET      = 3'h0;
   localparam logic [23:0] SHORT_RST       = 24'h00_0000;
   localparam logic [11:0] CMD_ERR_CLEAR   = 12'hA53;
   localparam int          WIN_SHORT_US    = 10;
   localparam int          WIN_LONG_US     = 20;
   localparam int          CLK_MHZ         = 100;
   localparam int          WIN_SHORT_CYC   = WIN_SHORT_US * CLK_MHZ;
   localparam int          WIN_LONG_CYC    = WIN_LONG_US * CLK_MHZ;
   localparam int          EARLY_EDGE      = 9;
   localparam logic [11:0] LATE_EDGE_12    = 12'hFFF;
   localparam logic [11:0] LATE_EDGE_10    = 12'h3FF;
   localparam logic [11:0] LATE_EDGE_8     = 12'h0FF;
   localparam int          STAT_W          = 10;

   typedef enum logic [2:0] {
      LFD_IDLE  = 3'b001,
      LFD_PROBE = 3'b010,
      LFD_DONE  = 3'b100
   } lfd_state_t;

   typedef struct packed {
      logic ref_short;
      logic ref_open;
      logic overheat_warn;
      logic overheat_shut;
   } lfd_analog_t;

   typedef struct packed {
      logic [2:0] short_check_result_code;
      logic [2:0] detector_selftest_code;
      logic       ref_short_flag;
      logic       ref_open_flag;
      logic       overheat_warning_flag;
      logic       overheat_shutdown_flag;
   } lfd_status_t;
endpackage

// ### lfd_diag.sv
// Functional notes
// - Short check runs only on host command, ideally with channels off.
// - No short: result code becomes pass, short register stays zero.
// - Short found: fail code latched, affected output bits set.
// - Short bits 0-7 red, 8-15 green, 16-23 blue outputs.
// - Result code and short register are zero after reset.
// - Failed short check pulls fault pin low until clear with short gone.
// - Window select picks 10 or 20 us; second bit picks probe current.
// - Reference open/short flags reset zero, set on fault, pull pin.
// - Reference fault forces 10 mA current limit while present.
// - Reference flags stay until fault gone and error clear.
// - Warning flag holds until cooled and error clear.
// - Shutdown turns outputs off, sets flag, holds until clear.
// - Digital logic keeps running in shutdown; outputs resume when cooled.
// - Invert markers reset zero, go to one on toggle, results inverted.
// - Early results latch at edge 9, late results at edge N.
// - Self-test code resets zero, pass code when detector fine.
// - Self-test fail sets fail code, pulls pin, holds until clear.
// - Open-drain active-low fault pin; mask resets one, hides LED faults.
// - Clear command code A53h resets removed faults, loads readout.
// - Late edge N is 4095, 1023 or 255 by mode.
`timescale 1ns/1ps
`default_nettype none
module lfd_diag
   import lfd_pkg::*;
#(
   parameter int CH = 24
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Command strobes from the serial decoder
   input  wire logic              cmd_valid,
   input  wire logic [11:0]       cmd_code,
   input  wire logic              short_check_cmd,
   input  wire logic              negate_toggle_cmd,
   input  wire logic              selftest_cmd,
   // Function control bits
   input  wire logic              led_fault_pin_mask,
   input  wire logic              short_window_sel,
   input  wire logic              short_probe_current_sel,
   input  wire logic [1:0]        grayscale_mode,
   // Analog monitors
   input  wire lfd_analog_t       analog,
   input  wire logic [CH-1:0]     neighbour_pin_short,
   input  wire logic              selftest_fault,
   input  wire logic              led_fault,
   input  wire logic              pwm_fault,
   // Grayscale clock edge pulse and detector comparators
   input  wire logic              grayscale_clock,
   input  wire logic              cycle_restart,
   input  wire logic [2*CH-1:0]   detect_raw,
   // Results
   output logic [CH-1:0]          adjacent_short_result,
   output lfd_status_t            status_ff,
   output logic                   invert_marker_first,
   output logic                   invert_marker_second,
   output logic [2*CH-1:0]        early_detect_results,
   output logic [2*CH-1:0]        late_detect_results,
   output logic                   readout_load,
   // Output control
   output logic                   outputs_off,
   output logic                   current_limit_10ma,
   output logic                   probe_high_current,
   output logic                   probe_active,
   // Fault pin, open drain
   output logic                   fault_pin_value,
   output logic                   fault_pin_oe
);

   lfd_state_t    state_ff;
   logic [15:0]   win_cnt_ff;
   logic [CH-1:0] short_ff;
   logic [11:0]   gs_cnt_ff;
   logic          inv_ff;
   logic          err_clear;
   logic [11:0]   late_edge;
   logic          pin_pull;
   logic [CH-1:0] short_left;

   assign err_clear = cmd_valid && (cmd_code == CMD_ERR_CLEAR);

   // Bits still shorted now; a clear may only drop the others
   assign short_left = short_ff & neighbour_pin_short;

   always_comb begin
      case (grayscale_mode)
         2'b10:   late_edge = LATE_EDGE_10;
         2'b11:   late_edge = LATE_EDGE_8;
         default: late_edge = LATE_EDGE_12;
      endcase
   end

   // Short check sequencer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= LFD_IDLE;
         win_cnt_ff <= 16'h0000;
         short_ff   <= SHORT_RST;
      end else begin
         case (state_ff)
            LFD_IDLE: begin
               if (short_check_cmd) begin
                  state_ff   <= LFD_PROBE;
                  win_cnt_ff <= short_window_sel ? 16'(WIN_LONG_CYC - 1)
                                                 : 16'(WIN_SHORT_CYC - 1);
                  short_ff   <= SHORT_RST;
               end else if (err_clear) begin
                  short_ff   <= short_left;
               end
            end
            LFD_PROBE: begin
               short_ff <= short_ff | neighbour_pin_short;
               if (win_cnt_ff == 16'h0000) begin
                  state_ff <= LFD_DONE;
               end else begin
                  win_cnt_ff <= win_cnt_ff - 16'h0001;
               end
            end
            LFD_DONE: state_ff <= LFD_IDLE;
            default:  state_ff <= LFD_IDLE;
         endcase
      end
   end

   // Error status flags; a fault present at clear keeps its flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= '0;
      end else begin
         if (state_ff == LFD_DONE) begin
            status_ff.short_check_result_code <= (short_ff != SHORT_RST) ? CODE_FAIL
                                                                         : CODE_PASS;
         end else if (err_clear && status_ff.short_check_result_code == CODE_FAIL
                      && short_left == SHORT_RST) begin
            status_ff.short_check_result_code <= CODE_RESET;
         end
         if (selftest_cmd) begin
            status_ff.detector_selftest_code <= selftest_fault ? CODE_FAIL : CODE_PASS;
         end else if (err_clear && !selftest_fault) begin
            status_ff.detector_selftest_code <= CODE_RESET;
         end
         status_ff.ref_short_flag <= analog.ref_short
                                   | (status_ff.ref_short_flag & ~err_clear);
         status_ff.ref_open_flag <= analog.ref_open
                                  | (status_ff.ref_open_flag & ~err_clear);
         status_ff.overheat_warning_flag <= analog.overheat_warn
                                          | (status_ff.overheat_warning_flag & ~err_clear);
         status_ff.overheat_shutdown_flag <= analog.overheat_shut
                                           | (status_ff.overheat_shutdown_flag & ~err_clear);
      end
   end

   // Grayscale counter and detector latches
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gs_cnt_ff            <= 12'h000;
         inv_ff               <= 1'b0;
         early_detect_results <= '0;
         late_detect_results  <= '0;
      end else begin
         if (negate_toggle_cmd) begin
            inv_ff <= 1'b1;
         end
         if (cycle_restart) begin
            gs_cnt_ff <= 12'h000;
         end else if (grayscale_clock) begin
            gs_cnt_ff <= gs_cnt_ff + 12'h001;
            if (gs_cnt_ff + 12'h001 == 12'(EARLY_EDGE)) begin
               early_detect_results <= detect_raw ^ {2*CH{inv_ff}};
            end
            if (gs_cnt_ff + 12'h001 == late_edge) begin
               late_detect_results <= detect_raw ^ {2*CH{inv_ff}};
            end
         end
      end
   end

   assign pin_pull = (status_ff.short_check_result_code == CODE_FAIL)
                   | (status_ff.detector_selftest_code == CODE_FAIL)
                   | status_ff.ref_short_flag | status_ff.ref_open_flag
                   | status_ff.overheat_warning_flag | status_ff.overheat_shutdown_flag
                   | (~led_fault_pin_mask & (led_fault | pwm_fault));

   // Registered outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adjacent_short_result <= SHORT_RST;
         invert_marker_first   <= 1'b0;
         invert_marker_second  <= 1'b0;
         readout_load          <= 1'b0;
         outputs_off           <= 1'b0;
         current_limit_10ma    <= 1'b0;
         probe_high_current    <= 1'b0;
         probe_active          <= 1'b0;
         fault_pin_value       <= 1'b0;
         fault_pin_oe          <= 1'b0;
      end else begin
         adjacent_short_result <= short_ff;
         invert_marker_first   <= inv_ff;
         invert_marker_second  <= inv_ff;
         readout_load          <= err_clear;
         outputs_off           <= analog.overheat_shut;
         current_limit_10ma    <= analog.ref_short | analog.ref_open;
         probe_high_current    <= short_probe_current_sel;
         probe_active          <= (state_ff == LFD_PROBE);
         fault_pin_value       <= 1'b0;
         fault_pin_oe          <= pin_pull;
      end
   end

   // Checks
   property p_pass_code;
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == LFD_DONE && short_ff == SHORT_RST)
         |=> status_ff.short_check_result_code == CODE_PASS;
   endproperty
   a_pass_code: assert property (p_pass_code) else $error("pass code missing");

   property p_fail_code;
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == LFD_DONE && short_ff != SHORT_RST)
         |=> status_ff.short_check_result_code == CODE_FAIL ##1 fault_pin_oe;
   endproperty
   a_fail_code: assert property (p_fail_code) else $error("fail code or pin");

   property p_only_cmd;
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == LFD_IDLE && !short_check_cmd) |=> state_ff != LFD_PROBE;
   endproperty
   a_only_cmd: assert property (p_only_cmd) else $error("check without command");

   property p_window;
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == LFD_IDLE && short_check_cmd && !short_window_sel)
         |=> (state_ff == LFD_PROBE) [*8];
   endproperty
   a_window: assert property (p_window) else $error("window too short");

   property p_ref_limit;
      @(posedge core_clk) disable iff (!rst_n)
      (analog.ref_short || analog.ref_open) |=> current_limit_10ma && status_ff.ref_short_flag | status_ff.ref_open_flag;
   endproperty
   a_ref_limit: assert property (p_ref_limit) else $error("no current limit");

   property p_flag_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (status_ff.overheat_warning_flag && !err_clear) |=> status_ff.overheat_warning_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("warning flag lost");

   property p_shut_off;
      @(posedge core_clk) disable iff (!rst_n)
      analog.overheat_shut |=> outputs_off && status_ff.overheat_shutdown_flag ##1 fault_pin_oe;
   endproperty
   a_shut_off: assert property (p_shut_off) else $error("shutdown not applied");

   property p_markers;
      @(posedge core_clk) disable iff (!rst_n)
      negate_toggle_cmd |=> ##1 (invert_marker_first && invert_marker_second);
   endproperty
   a_markers: assert property (p_markers) else $error("markers not set");

   property p_selftest;
      @(posedge core_clk) disable iff (!rst_n)
      (selftest_cmd && selftest_fault) |=> status_ff.detector_selftest_code == CODE_FAIL ##1 fault_pin_oe;
   endproperty
   a_selftest: assert property (p_selftest) else $error("self-test fail lost");

   property p_mask;
      @(posedge core_clk) disable iff (!rst_n)
      (pin_pull == 1'b0) |=> !fault_pin_oe;
   endproperty
   a_mask: assert property (p_mask) else $error("pin pulled without cause");

   property p_pin_pull;
      @(posedge core_clk) disable iff (!rst_n)
      pin_pull |=> fault_pin_oe && !fault_pin_value;
   endproperty
   a_pin_pull: assert property (p_pin_pull) else $error("pin not pulled low");

   // Checker helper: probe length, measured apart from the window counter
   logic [15:0] probe_len_ff;
   logic        long_win_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         probe_len_ff <= 16'h0000;
         long_win_ff  <= 1'b0;
      end else if (state_ff == LFD_IDLE) begin
         probe_len_ff <= 16'h0000;
         long_win_ff  <= short_window_sel;
      end else if (state_ff == LFD_PROBE) begin
         probe_len_ff <= probe_len_ff + 16'h0001;
      end
   end

   property p_window_len;
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == LFD_DONE)
         |-> probe_len_ff == (long_win_ff ? 16'(WIN_LONG_CYC) : 16'(WIN_SHORT_CYC));
   endproperty
   a_window_len: assert property (p_window_len) else $error("window length wrong");

   property p_short_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (status_ff.short_check_result_code == CODE_FAIL && !err_clear && state_ff != LFD_DONE)
         |=> status_ff.short_check_result_code == CODE_FAIL;
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("fail code lost");

   property p_early_only;
      @(posedge core_clk) disable iff (!rst_n)
      !(grayscale_clock && gs_cnt_ff == 12'(EARLY_EDGE - 1)) |=> $stable(early_detect_results);
   endproperty
   a_early_only: assert property (p_early_only) else $error("early set off its edge");

   property p_late_only;
      @(posedge core_clk) disable iff (!rst_n)
      !(grayscale_clock && gs_cnt_ff == late_edge - 12'h001) |=> $stable(late_detect_results);
   endproperty
   a_late_only: assert property (p_late_only) else $error("late set off its edge");

   property p_limit_release;
      @(posedge core_clk) disable iff (!rst_n)
      !(analog.ref_short || analog.ref_open) |=> !current_limit_10ma;
   endproperty
   a_limit_release: assert property (p_limit_release) else $error("limit kept");

   property p_outputs_resume;
      @(posedge core_clk) disable iff (!rst_n)
      !analog.overheat_shut |=> !outputs_off;
   endproperty
   a_outputs_resume: assert property (p_outputs_resume) else $error("outputs kept off");

   property p_readout;
      @(posedge core_clk) disable iff (!rst_n)
      err_clear |=> readout_load;
   endproperty
   a_readout: assert property (p_readout) else $error("readout not loaded");

   c_short_fail: cover property (@(posedge core_clk) disable iff (!rst_n)
      status_ff.short_check_result_code == CODE_FAIL);
   c_selftest_pass: cover property (@(posedge core_clk) disable iff (!rst_n)
      status_ff.detector_selftest_code == CODE_PASS);
   c_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
      fault_pin_oe ##1 err_clear ##2 !fault_pin_oe);
   c_long_window: cover property (@(posedge core_clk) disable iff (!rst_n)
      state_ff == LFD_DONE && long_win_ff);
endmodule
`default_nettype wire

// ### lfd_host.sv
`timescale 1ns/1ps
`default_nettype none
module lfd_host
   import lfd_pkg::*;
(
   // Clock
   input  wire logic  core_clk,
   // Command strobes
   output logic       cmd_valid,
   output logic [11:0] cmd_code,
   output logic       short_check_cmd,
   output logic       negate_toggle_cmd,
   output logic       selftest_cmd
);
   initial begin
      {cmd_valid, short_check_cmd, negate_toggle_cmd, selftest_cmd} = 4'h0;
      cmd_code = 12'h000;
   end
   // One-cycle pulse; a full idle cycle follows so strobes never merge
   task automatic send(input int kind);
      @(negedge core_clk);
      cmd_valid         = (kind == 0);
      cmd_code          = (kind == 0) ? CMD_ERR_CLEAR : 12'h000;
      short_check_cmd   = (kind == 1);
      negate_toggle_cmd = (kind == 2);
      selftest_cmd      = (kind == 3);
      @(negedge core_clk);
      {cmd_valid, short_check_cmd, negate_toggle_cmd, selftest_cmd} = 4'h0;
      cmd_code = 12'h000;
   endtask
   // Anything but pass or fail means the checker itself is broken
   function automatic logic code_ok(input logic [2:0] c);
      return (c === CODE_PASS) || (c === CODE_FAIL);
   endfunction
endmodule
`default_nettype wire

// ### led_driver_fault_diagnostics_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module led_driver_fault_diagnostics_tb_top
   import lfd_pkg::*;
;
   logic        core_clk = 1'b0, rst_n = 1'b0;
   logic        cmd_valid, short_check_cmd, negate_toggle_cmd, selftest_cmd;
   logic [11:0] cmd_code;
   logic        led_fault_pin_mask = 1'b1, short_window_sel = 1'b0;
   logic        short_probe_current_sel = 1'b0;
   logic [1:0]  grayscale_mode = 2'b00;
   lfd_analog_t analog = '0;
   logic [23:0] neighbour_pin_short = 24'h00_0000, adjacent_short_result;
   logic        selftest_fault = 1'b0, led_fault = 1'b0, pwm_fault = 1'b0;
   logic        grayscale_clock = 1'b0, cycle_restart = 1'b0;
   logic [47:0] detect_raw = 48'h0123_4567_89ab;
   logic [47:0] early_detect_results, late_detect_results;
   lfd_status_t status_ff;
   logic        invert_marker_first, invert_marker_second, readout_load;
   logic        outputs_off, current_limit_10ma, probe_high_current;
   logic        probe_active, fault_pin_value, fault_pin_oe;
   int          error_cnt = 0, num_checks = 0;
   // Pin level with the board pull-up
   wire         fault_n = fault_pin_oe ? fault_pin_value : 1'b1;

   always #5 core_clk = ~core_clk;

   lfd_host host (.core_clk, .cmd_valid, .cmd_code, .short_check_cmd,
      .negate_toggle_cmd, .selftest_cmd);

   lfd_diag dut (.core_clk, .rst_n, .cmd_valid, .cmd_code, .short_check_cmd,
      .negate_toggle_cmd, .selftest_cmd, .led_fault_pin_mask, .short_window_sel,
      .short_probe_current_sel, .grayscale_mode, .analog, .neighbour_pin_short,
      .selftest_fault, .led_fault, .pwm_fault, .grayscale_clock, .cycle_restart,
      .detect_raw, .adjacent_short_result, .status_ff, .invert_marker_first,
      .invert_marker_second, .early_detect_results, .late_detect_results,
      .readout_load, .outputs_off, .current_limit_10ma, .probe_high_current,
      .probe_active, .fault_pin_value, .fault_pin_oe);

   task automatic summarize();
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic clr();
      logic seen;
      host.send(0);
      seen = readout_load;
      repeat (4) begin
         tick(1);
         seen = seen | readout_load;
      end
      chk(seen, 1'b1);
      tick(2);
   endtask

   task automatic run_check(input logic win, input logic [23:0] sh, input logic [2:0] code);
      int n;
      int cyc;
      short_window_sel = win;
      short_probe_current_sel = win;
      neighbour_pin_short = sh;
      host.send(1);
      n = 0;
      for (cyc = 0; !(n > 0 && probe_active === 1'b0); cyc++) begin
         if (cyc > 2200) begin
            error_cnt++;
            summarize();
         end
         if (probe_active === 1'b1) n++;
         if (probe_active === 1'b1 && n == 1) chk(probe_high_current, win);
         tick(1);
      end
      tick(4);
      chk(n, win ? WIN_LONG_CYC : WIN_SHORT_CYC);
      chk({status_ff.short_check_result_code, adjacent_short_result}, {code, sh});
      chk(host.code_ok(status_ff.short_check_result_code), 1'b1);
   endtask

   // One grayscale cycle; comparator levels change right after edge 9
   task automatic gs_run(input logic [1:0] mode, input int pulses, input logic [47:0] late_raw);
      int k;
      grayscale_mode = mode;
      cycle_restart = 1'b1;
      tick(1);
      cycle_restart = 1'b0;
      for (k = 1; k <= pulses; k++) begin
         grayscale_clock = 1'b1;
         tick(1);
         grayscale_clock = 1'b0;
         if (k == 9) detect_raw = late_raw;
         tick(1);
      end
      tick(4);
   endtask

   initial begin
      int i;
      tick(12);
      rst_n = 1'b1;
      tick(2);
      chk({adjacent_short_result, status_ff, invert_marker_first, invert_marker_second,
         fault_pin_oe}, '0);
      run_check(1'b0, 24'h00_0000, CODE_PASS);
      run_check(1'b1, 24'h80_0101, CODE_FAIL);
      chk({fault_pin_oe, fault_n}, 2'b10);
      clr();
      chk({status_ff.short_check_result_code, adjacent_short_result, fault_pin_oe},
         {CODE_FAIL, 24'h80_0101, 1'b1});
      neighbour_pin_short = 24'h00_0000;
      clr();
      chk({status_ff, adjacent_short_result, fault_pin_oe}, '0);
      for (i = 0; i < 4; i++) begin
         analog = lfd_analog_t'(4'b1000 >> i);
         tick(4);
         chk({status_ff[3:0], fault_pin_oe}, {4'b1000 >> i, 1'b1});
         chk({current_limit_10ma, outputs_off}, {i < 2, i == 3});
         analog = '0;
         tick(4);
         chk({status_ff[3:0], fault_pin_oe}, {4'b1000 >> i, 1'b1});
         chk({current_limit_10ma, outputs_off}, 2'b00);
         clr();
         chk({status_ff[3:0], fault_pin_oe}, '0);
      end
      host.send(3);
      tick(4);
      chk(status_ff.detector_selftest_code, CODE_PASS);
      selftest_fault = 1'b1;
      host.send(3);
      tick(4);
      chk({status_ff.detector_selftest_code, fault_pin_oe}, {CODE_FAIL, 1'b1});
      chk(host.code_ok(status_ff.detector_selftest_code), 1'b1);
      selftest_fault = 1'b0;
      clr();
      chk({status_ff.detector_selftest_code, fault_pin_oe}, '0);
      led_fault = 1'b1;
      tick(4);
      chk(fault_pin_oe, 1'b0);
      led_fault_pin_mask = 1'b0;
      tick(4);
      chk(fault_pin_oe, 1'b1);
      {led_fault, pwm_fault} = 2'b01;
      tick(4);
      chk(fault_pin_oe, 1'b1);
      pwm_fault = 1'b0;
      tick(4);
      chk(fault_pin_oe, 1'b0);
      gs_run(2'b10, 1023, 48'hfedc_ba98_7654);
      chk(early_detect_results, 48'h0123_4567_89ab);
      chk(late_detect_results, 48'hfedc_ba98_7654);
      gs_run(2'b01, 4095, 48'h0123_4567_89ab);
      chk(early_detect_results, 48'hfedc_ba98_7654);
      chk(late_detect_results, 48'h0123_4567_89ab);
      host.send(2);
      tick(4);
      chk({invert_marker_first, invert_marker_second}, 2'b11);
      gs_run(2'b11, 256, 48'h0123_4567_89ab);
      tick(4);
      chk(early_detect_results, ~detect_raw);
      chk(late_detect_results, ~detect_raw);
      summarize();
   end
endmodule
`default_nettype wire
